// ==== hw/gmrx_mac.sv ====
// receive mac: gmii/mii sampling, framing, fifo push, statistics, host port
`timescale 1ns/1ps
`include "gmrx_params.svh"
module gmrx_mac (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic gbit_en_i,
    input wire logic rx_en_i,
    input wire logic drop_req_i,
    input wire logic [7:0] rxd_i,
    input wire logic rx_dv_i,
    input wire logic rx_er_i,
    input wire logic fifo_full_i,
    output logic push_o,
    output logic [7:0] push_data_o,
    output logic eof_o,
    output logic frame_err_o,
    output logic fifo_ovf_o,
    output logic stat_en_o,
    output logic [31:0] stat_o,
    output logic rx_idle_o,
    input wire logic hcs_n_i,
    input wire logic hread_n_i,
    input wire logic hwrite_n_i,
    input wire logic [7:0] haddr_i,
    input wire logic [15:0] hwdata_i,
    output logic [15:0] hrdata_o,
    output logic hready_n_o
);
    gmrx_pkg::gmrx_state_s q;
    gmrx_pkg::gmrx_state_s d;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ `GMRX_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    logic dv;
    logic rise;
    logic step;
    logic [7:0] rbyte;
    logic wr_en;
    logic [7:0] wr_data;
    logic pop;
    logic wr_ok;
    logic [15:0] idx;
    logic crc_bad;
    logic len_err;
    logic short_f;
    logic long_f;
    logic hreq;

    always_comb begin
        d = q;
        dv = q.f[8];
        rise = dv & ~q.dv_prev;
        step = gbit_en_i | (q.half & ~rise);
        rbyte = gbit_en_i ? q.f[7:0] : {q.f[3:0], q.nib};
        wr_en = 1'b0;
        wr_data = rbyte;
        pop = (q.bcnt != 2'h0) & ~fifo_full_i;
        wr_ok = 1'b0;
        idx = q.cnt - 16'(`GMRX_FCS_N);
        crc_bad = q.crc != `GMRX_CRC_RES;
        short_f = q.cnt < `GMRX_MIN_LEN;
        long_f = q.cnt > `GMRX_MAX_LEN;
        len_err = (q.len < `GMRX_TYPE_MIN) &&
            ((q.len < `GMRX_PAD_LIM) ? (q.cnt != `GMRX_MIN_LEN)
                                     : (q.cnt != q.len + `GMRX_OVH_LEN));
        hreq = ~hcs_n_i & (hread_n_i ^ hwrite_n_i);
        if (ce_i) begin
            // three-stage sampling, accepted once stages two and three agree
            d.s1 = {rx_er_i, rx_dv_i, rxd_i};
            d.s2 = q.s1;
            d.s3 = q.s2;
            // bytes change every clock, so only valid waits for agreement;
            // data and error ride along with stage three, aligned to valid
            d.f = {q.s3[9], q.f[8], q.s3[7:0]};
            if (q.s2[8] == q.s3[8]) begin
                d.f[8] = q.s3[8];
            end
            d.ds = {q.ds[1:0], drop_req_i};
            if (q.ds[1] == q.ds[2]) begin
                d.drop_f = q.ds[2];
            end
            d.dv_prev = dv;
            // nibble phase realigned on carrier rise
            d.half = rise | ~q.half;
            if (rise | ~q.half) begin
                d.nib = q.f[3:0];
            end
            d.eof = 1'b0;
            d.err = 1'b0;
            d.ovfo = 1'b0;
            d.stat_en = 1'b0;
            if (step && !dv && q.ipg != `GMRX_IPG_BYTES) begin
                d.ipg = q.ipg + 4'h1;
            end
            case (q.st)
                gmrx_pkg::GMRX_IDLE: begin
                    if (step && dv && rx_en_i) begin
                        d.st = gmrx_pkg::GMRX_PRE;
                        d.ipg_bad = q.ipg != `GMRX_IPG_BYTES;
                        d.ipg = 4'h0;
                    end
                end
                gmrx_pkg::GMRX_PRE: begin
                    if (!dv) begin
                        d.st = gmrx_pkg::GMRX_IDLE;
                    end else if (step && rbyte == `GMRX_SFD) begin
                        d.crc = `GMRX_CRC_INIT;
                        d.cnt = 16'h0;
                        d.dly_n = 3'h0;
                        d.len = 16'h0;
                        d.rxer = 1'b0;
                        d.ovf = 1'b0;
                        d.strip = q.ctl[`GMRX_CTL_STRIP];
                        d.ign = q.drop_f;
                        d.st = q.drop_f ? gmrx_pkg::GMRX_DROP : gmrx_pkg::GMRX_DATA;
                    end
                end
                gmrx_pkg::GMRX_DATA: begin
                    // rx_en deliberately not looked at: a started frame runs out
                    if (step && dv) begin
                        d.crc = crc_byte(q.crc, rbyte);
                        d.cnt = q.cnt + 16'h1;
                        d.rxer = q.rxer | q.f[9];
                        if (q.cnt == `GMRX_LEN_HI) begin
                            d.len[15:8] = rbyte;
                        end
                        if (q.cnt == `GMRX_LEN_LO) begin
                            d.len[7:0] = rbyte;
                        end
                        if (!q.strip) begin
                            wr_en = 1'b1;
                        end else begin
                            // four-byte delay so the check sequence is never pushed
                            d.dly = {q.dly[2:0], rbyte};
                            if (q.dly_n != `GMRX_FCS_N) begin
                                d.dly_n = q.dly_n + 3'h1;
                            end else begin
                                wr_data = q.dly[3];
                                wr_en = !(q.len < `GMRX_PAD_LIM &&
                                    idx >= `GMRX_HDR_LEN + q.len);
                            end
                        end
                    end else if (step) begin
                        d.st = gmrx_pkg::GMRX_END;
                    end
                end
                gmrx_pkg::GMRX_DROP: begin
                    if (step && !dv) begin
                        d.st = gmrx_pkg::GMRX_END;
                    end
                end
                gmrx_pkg::GMRX_END: begin
                    // wait until the last byte has left the push register
                    if (q.bcnt == 2'h0 && !q.push) begin
                        d.st = gmrx_pkg::GMRX_IDLE;
                        d.stat_en = 1'b1;
                        d.stat = 32'h0;
                        d.stat[15:0] = q.cnt;
                        if (q.ign) begin
                            d.stat[`GMRX_ST_IGN] = 1'b1;
                        end else begin
                            d.eof = 1'b1;
                            d.err = q.rxer | crc_bad | len_err;
                            d.ovfo = q.ovf;
                            d.stat[31:29] = {long_f, short_f, q.ipg_bad};
                            d.stat[25:23] = {crc_bad, len_err,
                                ~(q.rxer | crc_bad | len_err | q.ovf | short_f)};
                        end
                        // status: long,short,ipg,ignored,crc,len,ok,phy error,overflow
                        d.sts = {d.stat[31:29], d.stat[26:23], q.rxer & ~q.ign,
                            q.ovf & ~q.ign};
                    end
                end
                default: begin
                    d.st = gmrx_pkg::GMRX_IDLE;
                end
            endcase
            // two-entry buffer; a byte arriving while both entries wait and fifo_full_i holds the pop back is lost
            if (wr_en) begin
                if (q.bcnt == `GMRX_BUF_N && !pop) begin
                    d.ovf = 1'b1;
                end else begin
                    wr_ok = 1'b1;
                    d.buf_m[q.wp] = wr_data;
                    d.wp = ~q.wp;
                end
            end
            d.push = pop;
            if (pop) begin
                d.dout = q.buf_m[q.rp];
                d.rp = ~q.rp;
            end
            d.bcnt = q.bcnt + {1'b0, wr_ok} - {1'b0, pop};
            d.idle = d.st == gmrx_pkg::GMRX_IDLE;
            // host port: one acknowledge per strobe, rearmed when strobes drop
            d.hrdy_n = 1'b1;
            if (hreq && !q.hbusy) begin
                d.hrdy_n = 1'b0;
                d.hbusy = 1'b1;
                if (!hwrite_n_i && haddr_i == `GMRX_ADDR_CTL) begin
                    d.ctl = hwdata_i;
                end
                if (!hread_n_i) begin
                    d.hrd = (haddr_i == `GMRX_ADDR_CTL) ? q.ctl :
                        (haddr_i == `GMRX_ADDR_STS) ? {5'h0, q.idle, q.sts, 1'b0} :
                        16'h0;
                end
            end
            if (!hreq) begin
                d.hbusy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.st <= gmrx_pkg::GMRX_IDLE;
            q.idle <= 1'b1;
            q.hrdy_n <= 1'b1;
            q.half <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign push_o = q.push;
    assign push_data_o = q.dout;
    assign eof_o = q.eof;
    assign frame_err_o = q.err;
    assign fifo_ovf_o = q.ovfo;
    assign stat_en_o = q.stat_en;
    assign stat_o = q.stat;
    assign rx_idle_o = q.idle;
    assign hrdata_o = q.hrd;
    assign hready_n_o = q.hrdy_n;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence s_host_req;
        ce_i && hreq && !q.hbusy;
    endsequence
    sequence s_ack_once;
        !hready_n_o ##1 hready_n_o;
    endsequence

    a_err_with_eof: assert property (frame_err_o |-> eof_o)
        else $error("frame error without end of frame");
    a_ovf_with_eof: assert property (fifo_ovf_o |-> eof_o)
        else $error("overrun flag without end of frame");
    a_eof_has_stat: assert property (eof_o |-> stat_en_o && !push_o)
        else $error("end of frame without statistics strobe");
    a_idle_status: assert property ((ce_i && d.st == gmrx_pkg::GMRX_IDLE) |=> rx_idle_o)
        else $error("idle status not shown");
    a_disabled_stays: assert property (
        (ce_i && q.st == gmrx_pkg::GMRX_IDLE && !rx_en_i) |=>
        q.st == gmrx_pkg::GMRX_IDLE)
        else $error("receiver left idle while disabled");
    a_host_ack: assert property (s_host_req |=> s_ack_once)
        else $error("host access not acknowledged exactly once");
    a_sfd_enters: assert property (
        (ce_i && q.st == gmrx_pkg::GMRX_PRE && dv && step && rbyte == `GMRX_SFD) |=>
        q.st == (q.ign ? gmrx_pkg::GMRX_DROP : gmrx_pkg::GMRX_DATA))
        else $error("delimiter did not start the frame");
    a_half_rate: assert property (
        (ce_i && !gbit_en_i && q.half && !rise) |=> !q.half)
        else $error("10/100 receive step not halved");
    a_ignored_silent: assert property (
        (stat_en_o && stat_o[`GMRX_ST_IGN]) |-> !eof_o)
        else $error("ignored frame signalled to fifo");

    // one-cycle pulses, else the fifo side would count a frame twice
    a_eof_pulse: assert property ((ce_i && eof_o) |=> !eof_o)
        else $error("end of frame longer than one cycle");
    a_stat_pulse: assert property ((ce_i && stat_en_o) |=> !stat_en_o)
        else $error("statistics strobe longer than one cycle");
    a_full_stalls: assert property ((ce_i && fifo_full_i) |=> !push_o)
        else $error("push while fifo full");
    a_buf_bound: assert property (q.bcnt <= `GMRX_BUF_N)
        else $error("buffer count beyond two entries");
    a_drop_silent: assert property (
        (ce_i && q.st == gmrx_pkg::GMRX_DROP && q.bcnt == 2'h0 && !q.push) |=> !push_o)
        else $error("dropped frame pushed");
    a_end_to_idle: assert property (
        (ce_i && q.st == gmrx_pkg::GMRX_END && q.bcnt == 2'h0 && !q.push) |=> rx_idle_o)
        else $error("receiver not idle after frame end");
    a_gbit_count: assert property (
        (ce_i && gbit_en_i && q.st == gmrx_pkg::GMRX_DATA && dv) |=>
        q.cnt == $past(q.cnt) + 16'h1)
        else $error("gigabit byte not taken every clock");
    a_ack_single: assert property ((ce_i && !hready_n_o) |=> hready_n_o)
        else $error("acknowledge longer than one cycle");
endmodule // gmrx_mac

// ==== pkg/gmrx_params.svh ====
// constants of the gigabit/mii receive mac and its host port
`ifndef GMRX_PARAMS_SVH
`define GMRX_PARAMS_SVH
`define GMRX_SFD 8'hd5
`define GMRX_CRC_INIT 32'hffffffff
`define GMRX_CRC_POLY 32'hedb88320
`define GMRX_CRC_RES 32'hdebb20e3
`define GMRX_MIN_LEN 16'h0040
`define GMRX_PAD_LIM 16'h002e
`define GMRX_HDR_LEN 16'h000e
`define GMRX_OVH_LEN 16'h0012
`define GMRX_FCS_N 3'h4
`define GMRX_LEN_HI 16'h000c
`define GMRX_LEN_LO 16'h000d
`define GMRX_TYPE_MIN 16'h0600
`define GMRX_MAX_LEN 16'h05ee
`define GMRX_IPG_BYTES 4'hc
`define GMRX_ADDR_CTL 8'h00
`define GMRX_ADDR_STS 8'h04
`define GMRX_CTL_STRIP 1
`define GMRX_ST_IGN 26
`define GMRX_BUF_N 2'h2
`endif

// ==== pkg/gmrx_pkg.sv ====
// types of the receive mac: state machine and packed state
package gmrx_pkg;
    typedef enum logic [4:0] {
        GMRX_IDLE = 5'h01,
        GMRX_PRE = 5'h02,
        GMRX_DATA = 5'h04,
        GMRX_DROP = 5'h08,
        GMRX_END = 5'h10
    } gmrx_state_e;

    typedef struct packed {
        logic [9:0] s1;
        logic [9:0] s2;
        logic [9:0] s3;
        logic [9:0] f;
        logic [2:0] ds;
        logic drop_f;
        logic dv_prev;
        logic half;
        logic [3:0] nib;
        gmrx_state_e st;
        logic [15:0] cnt;
        logic [31:0] crc;
        logic [3:0][7:0] dly;
        logic [2:0] dly_n;
        logic [15:0] len;
        logic [3:0] ipg;
        logic ipg_bad;
        logic rxer;
        logic ign;
        logic strip;
        logic ovf;
        logic [1:0][7:0] buf_m;
        logic wp;
        logic rp;
        logic [1:0] bcnt;
        logic push;
        logic [7:0] dout;
        logic eof;
        logic err;
        logic ovfo;
        logic stat_en;
        logic [31:0] stat;
        logic idle;
        logic [9:1] sts;
        logic [15:0] ctl;
        logic hrdy_n;
        logic hbusy;
        logic [15:0] hrd;
    } gmrx_state_s;
endpackage

// ==== sim/gmrx_phy_model.sv ====
// phy model: plays a queued frame onto gmii bytes or mii nibbles
`timescale 1ns/1ps
module gmrx_phy_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic gbit_i,
    output logic [7:0] rxd_o,
    output logic dv_o,
    output logic er_o
);
    logic [7:0] fr [$];
    int pos = 32'h7fffffff;
    int er_at = -1;

    // parked position keeps a half-filled queue from leaking out early
    task automatic start(input int e);
        @(negedge clk_i);
        er_at = e;
        pos = 0;
    endtask

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rxd_o <= 8'h00;
            dv_o <= 1'b0;
            er_o <= 1'b0;
        end else if (pos < (gbit_i ? fr.size() : 2 * fr.size())) begin
            dv_o <= 1'b1;
            er_o <= (pos == er_at);
            if (gbit_i) begin
                rxd_o <= fr[pos];
            end else begin
                // low nibble first; upper lines carry a moving pattern
                rxd_o <= {4'(pos), pos[0] ? fr[pos / 2][7:4] : fr[pos / 2][3:0]};
            end
            pos <= pos + 1;
        end else begin
            dv_o <= 1'b0;
            er_o <= 1'b0;
            rxd_o <= ~rxd_o;
            pos <= 32'h7fffffff;
        end
    end
endmodule // gmrx_phy_model

// ==== sim/tb_top.sv ====
// testbench of the receive mac: host accesses and frame scenarios
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic gbit_en_i = 1'b1;
    logic rx_en_i = 1'b1;
    logic drop_req_i = 1'b0;
    logic fifo_full_i = 1'b0;
    logic hcs_n_i = 1'b1;
    logic hread_n_i = 1'b1;
    logic hwrite_n_i = 1'b1;
    logic [7:0] haddr_i = 8'h00;
    logic [15:0] hwdata_i = 16'h0000;
    logic [7:0] rxd_i;
    logic rx_dv_i, rx_er_i, push_o, eof_o, frame_err_o, fifo_ovf_o, stat_en_o;
    logic rx_idle_o, hready_n_o;
    logic [7:0] push_data_o;
    logic [31:0] stat_o;
    logic [15:0] hrdata_o;
    int bad_count = 0;
    int check_count = 0;
    int n_eof = 0;
    int n_stat = 0;
    int e0;
    logic l_err, l_ovf;
    logic [31:0] l_stat;
    logic [7:0] got [$];
    logic [7:0] fb [0:63];
    logic [15:0] rd;

    always #20 clk_sys_i = ~clk_sys_i;

    gmrx_mac dut_u (.clk_sys_i, .resetn_i, .ce_i(1'b1), .gbit_en_i, .rx_en_i, .drop_req_i,
        .rxd_i, .rx_dv_i, .rx_er_i, .fifo_full_i, .push_o, .push_data_o, .eof_o, .frame_err_o,
        .fifo_ovf_o, .stat_en_o, .stat_o, .rx_idle_o, .hcs_n_i, .hread_n_i, .hwrite_n_i,
        .haddr_i, .hwdata_i, .hrdata_o, .hready_n_o);

    gmrx_phy_model phy_u (.clk_i(clk_sys_i), .resetn_i, .gbit_i(gbit_en_i), .rxd_o(rxd_i),
        .dv_o(rx_dv_i), .er_o(rx_er_i));

    always @(posedge clk_sys_i) begin
        if (push_o) got.push_back(push_data_o);
        if (eof_o) begin
            n_eof++;
            l_err = frame_err_o;
            l_ovf = fifo_ovf_o;
        end
        if (stat_en_o) begin
            n_stat++;
            l_stat = stat_o;
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task conclude;
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic hacc(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        int k;
        @(posedge clk_sys_i);
        hcs_n_i <= 1'b0;
        hwrite_n_i <= ~wr;
        hread_n_i <= wr;
        haddr_i <= a;
        hwdata_i <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys_i);
            if (hready_n_o === 1'b0) break;
        end
        q = hrdata_o;
        hcs_n_i <= 1'b1;
        hwrite_n_i <= 1'b1;
        hread_n_i <= 1'b1;
        if (k == 20) begin
            bad_count++;
            conclude();
        end
    endtask

    task automatic build(input logic [15:0] lt, input logic badf);
        logic [31:0] c;
        int i;
        for (i = 0; i < 60; i++) fb[i] = 8'(i) + 8'h20;
        fb[12] = lt[15:8];
        fb[13] = lt[7:0];
        c = 32'hffffffff;
        for (i = 0; i < 60; i++) begin
            c ^= {24'h000000, fb[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        c = ~c;
        for (i = 0; i < 4; i++) fb[60 + i] = c[8 * i +: 8];
        fb[63] ^= {7'h00, badf};
    endtask

    // full is let go once the phy is done, else the buffer never drains
    task automatic run(input int er_at, input logic want, input int mid);
        int k, n0;
        n0 = n_stat;
        got = {};
        phy_u.fr = {};
        repeat (7) phy_u.fr.push_back(8'h55);
        phy_u.fr.push_back(8'hd5);
        for (k = 0; k < 64; k++) phy_u.fr.push_back(fb[k]);
        phy_u.start(er_at);
        for (k = 0; k < 700; k++) begin
            @(posedge clk_sys_i);
            if (k == mid) rx_en_i <= 1'b0;
            if (phy_u.pos > 200) fifo_full_i <= 1'b0;
            if (want ? n_stat != n0 : k == 400) break;
        end
        if (k == 700) begin
            bad_count++;
            conclude();
        end
        if (!want) chk(32'(n_stat), 32'(n0));
        repeat (40) @(posedge clk_sys_i);
    endtask

    task automatic cmpb(input int n);
        chk(32'(got.size()), 32'(n));
        for (int i = 0; i < n && i < got.size(); i++) chk({24'h0, got[i]}, {24'h0, fb[i]});
    endtask

    initial begin
        repeat (20) @(posedge clk_sys_i);
        chk(32'({push_o, eof_o, stat_en_o, rx_idle_o, hready_n_o}), 32'h3);
        resetn_i <= 1'b1;
        hacc(1'b1, 8'h00, 16'h0005, rd);
        hacc(1'b0, 8'h00, 16'h0000, rd);
        chk(32'(rd), 32'h5);
        hacc(1'b0, 8'h04, 16'h0000, rd);
        chk(32'(rd[10]), 32'h1);
        hacc(1'b0, 8'h40, 16'h0000, rd);
        chk(32'(rd), 32'h0);
        hacc(1'b1, 8'h00, 16'h0000, rd);
        build(16'h0800, 1'b0);
        run(-1, 1'b1, -1);
        cmpb(64);
        chk(32'({l_err, l_stat[23], l_stat[15:0]}), 32'h10040);
        hacc(1'b0, 8'h04, 16'h0000, rd);
        chk(32'({rd[10], rd[3]}), 32'h3);
        build(16'h0800, 1'b1);
        run(-1, 1'b1, -1);
        chk(32'({l_err, l_stat[25]}), 32'h3);
        hacc(1'b0, 8'h04, 16'h0000, rd);
        chk(32'(rd[5]), 32'h1);
        build(16'h0800, 1'b0);
        run(30, 1'b1, -1);
        chk(32'(l_err), 32'h1);
        hacc(1'b1, 8'h00, 16'h0002, rd);
        build(16'h0010, 1'b0);
        run(-1, 1'b1, -1);
        cmpb(30);
        build(16'h0800, 1'b0);
        run(-1, 1'b1, -1);
        cmpb(60);
        hacc(1'b1, 8'h00, 16'h0000, rd);
        gbit_en_i <= 1'b0;
        run(-1, 1'b1, -1);
        cmpb(64);
        chk(32'(l_err), 32'h0);
        gbit_en_i <= 1'b1;
        rx_en_i <= 1'b0;
        run(-1, 1'b0, -1);
        chk(32'(got.size()), 32'h0);
        rx_en_i <= 1'b1;
        run(-1, 1'b1, 40);
        cmpb(64);
        rx_en_i <= 1'b1;
        drop_req_i <= 1'b1;
        e0 = n_eof;
        run(-1, 1'b1, -1);
        chk({31'(got.size()), l_stat[26]}, 32'h1);
        chk(32'(n_eof), 32'(e0));
        drop_req_i <= 1'b0;
        fifo_full_i <= 1'b1;
        run(-1, 1'b1, -1);
        chk(32'(l_ovf), 32'h1);
        conclude();
    end
endmodule // tb_top
